// ===== spc_port_ctrl.sv
// Purpose: Port one control register bank and the per-packet decisions it steers.
// Assumes: Packet descriptors and normal indicator levels come from logic on ref_clk.
// Notes:   Register reads return data in the cycle after the read strobe.
//
// Design decision made here: the plain strobed port.
module spc_port_ctrl (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Ingress descriptor
    input  wire logic        in_valid,
    input  wire logic        in_tagged,
    input  wire logic        in_sa_hit_one,
    input  wire logic        in_sa_hit_two,
    input  wire logic        in_bcast,
    input  wire logic        in_dscp_hit,
    input  wire logic [1:0]  in_dscp_prio,
    input  wire logic        in_tag_hit,
    input  wire logic [1:0]  in_tag_prio,
    // Ingress decision
    output logic             cls_valid,
    output logic             cls_drop,
    output logic             cls_saf,
    output logic             cls_storm,
    output logic      [1:0]  cls_prio,
    output logic      [1:0]  cls_queue,
    // Egress descriptor
    input  wire logic        eg_in_valid,
    input  wire logic        eg_tagged_rx,
    input  wire logic [11:0] eg_src_vid,
    // Egress decision
    output logic             eg_valid,
    output logic             eg_insert,
    output logic             eg_strip,
    output logic      [11:0] eg_vid,
    // Default VID of this port for other egress ports
    output logic      [11:0] default_vid,
    // Indicators
    input  wire logic        norm_zero,
    input  wire logic        norm_one,
    output logic             port_indicator_zero,
    output logic             port_indicator_one
);

    spc_pkg::spc_state_t s_ff;
    spc_pkg::spc_state_t nxt_s;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Maps a priority to an egress queue under the split setting.
    function automatic logic [1:0] queue_of(input logic [1:0] prio,
                                            input logic [15:0] ctrl);
        logic [1:0] q;
        q = 2'h0;
        if (ctrl[spc_pkg::B_FOUR_Q]) begin
            q = prio;
        end else if (ctrl[spc_pkg::B_TWO_Q]) begin
            q = {1'b0, prio[1]};
        end
        return q;
    endfunction

    // Combined classification: enabled results ORed, else port priority.
    function automatic logic [1:0] prio_of(input logic [15:0] ctrl,
                                           input logic dhit,
                                           input logic [1:0] dpri,
                                           input logic thit,
                                           input logic [1:0] tpri);
        logic       use_d;
        logic       use_t;
        logic [1:0] p;
        use_d = ctrl[spc_pkg::B_DSCP] & dhit;
        use_t = ctrl[spc_pkg::B_USRPRI] & thit;
        p = ctrl[spc_pkg::B_PPRI_HI:spc_pkg::B_PPRI_LO];
        if (use_d || use_t) begin
            p = (use_d ? dpri : 2'h0) | (use_t ? tpri : 2'h0);
        end
        return p;
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rdata = 16'h0000;
        // writes land at once, next packet sees them
        if (reg_wr) begin
            if (reg_addr == spc_pkg::OFS_CTRL) begin
                nxt_s.ctrl = reg_wdata & spc_pkg::CTRL_WMASK;
            end else if (reg_addr == spc_pkg::OFS_DTAG) begin
                nxt_s.dtag = reg_wdata;
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                spc_pkg::OFS_CTRL: begin
                    nxt_s.rdata = s_ff.ctrl;
                end
                spc_pkg::OFS_DTAG: begin
                    nxt_s.rdata = s_ff.dtag;
                end
                default: begin
                    nxt_s.rdata = 16'h0000;
                end
            endcase
        end

        nxt_s.cls_valid = in_valid;
        nxt_s.cls_drop = in_valid & in_tagged & s_ff.ctrl[spc_pkg::B_DROPTAG];
        nxt_s.cls_saf = in_valid
            & ((in_sa_hit_two & s_ff.ctrl[spc_pkg::B_SAF_TWO])
             | (in_sa_hit_one & s_ff.ctrl[spc_pkg::B_SAF_ONE]));
        nxt_s.cls_storm = in_valid & in_bcast & s_ff.ctrl[spc_pkg::B_STORM];
        nxt_s.cls_prio = prio_of(s_ff.ctrl, in_dscp_hit, in_dscp_prio,
                                 in_tag_hit, in_tag_prio);
        nxt_s.cls_queue = queue_of(nxt_s.cls_prio, s_ff.ctrl);

        nxt_s.eg_valid = eg_in_valid;
        nxt_s.eg_insert = eg_in_valid & ~eg_tagged_rx
            & s_ff.ctrl[spc_pkg::B_INSERT];
        nxt_s.eg_strip = eg_in_valid & eg_tagged_rx
            & s_ff.ctrl[spc_pkg::B_STRIP];
        nxt_s.eg_vid = eg_src_vid;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_ff <= '0;
            s_ff.ctrl <= spc_pkg::CTRL_RST;
            // default tag resets to VID one
            s_ff.dtag <= spc_pkg::DTAG_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign reg_rdata   = s_ff.rdata;
    assign cls_valid   = s_ff.cls_valid;
    assign cls_drop    = s_ff.cls_drop;
    assign cls_saf     = s_ff.cls_saf;
    assign cls_storm   = s_ff.cls_storm;
    assign cls_prio    = s_ff.cls_prio;
    assign cls_queue   = s_ff.cls_queue;
    assign eg_valid    = s_ff.eg_valid;
    assign eg_insert   = s_ff.eg_insert;
    assign eg_strip    = s_ff.eg_strip;
    assign eg_vid      = s_ff.eg_vid;
    assign default_vid = s_ff.dtag[spc_pkg::B_VID_HI:0];

    spc_led_ovr u_led (
        .ref_clk             (ref_clk),
        .srst                (srst),
        .led_mode            (s_ff.ctrl[spc_pkg::B_LED_HI:spc_pkg::B_LED_LO]),
        .norm_zero           (norm_zero),
        .norm_one            (norm_one),
        .port_indicator_zero (port_indicator_zero),
        .port_indicator_one  (port_indicator_one)
    );

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    ctrl_write_a: assert property (
        reg_wr && reg_addr == spc_pkg::OFS_CTRL
        ##1 reg_rd && reg_addr == spc_pkg::OFS_CTRL
        |=> reg_rdata == ($past(reg_wdata, 2) & spc_pkg::CTRL_WMASK))
        else $error("Written control value not read back.");

    dtag_reset_a: assert property (disable iff (1'b0)
        srst |=> default_vid == spc_pkg::VID_RST)
        else $error("Default VID not one after reset.");

    drop_tag_a: assert property (
        in_valid && in_tagged |=> cls_drop == s_ff.ctrl[spc_pkg::B_DROPTAG]
            || $past(reg_wr))
        else $error("Tagged drop does not follow its enable.");

    sa_filter_a: assert property (
        in_valid && in_sa_hit_two && !in_sa_hit_one
        && s_ff.ctrl[spc_pkg::B_SAF_TWO] |=> cls_saf)
        else $error("Second address filter not applied.");

    sa_filter_one_a: assert property (
        in_valid && !in_sa_hit_two && !s_ff.ctrl[spc_pkg::B_SAF_ONE]
        |=> !cls_saf)
        else $error("First address filter applied while off.");

    storm_en_a: assert property (
        in_valid && in_bcast && !s_ff.ctrl[spc_pkg::B_STORM] |=> !cls_storm)
        else $error("Storm check while disabled.");

    single_queue_a: assert property (
        !s_ff.ctrl[spc_pkg::B_TWO_Q] && !s_ff.ctrl[spc_pkg::B_FOUR_Q]
        && !reg_wr |=> cls_queue == 2'h0)
        else $error("Queue not zero with no split.");

    port_prio_a: assert property (
        in_valid && !in_dscp_hit && !in_tag_hit && !reg_wr
        |=> cls_prio == $past(s_ff.ctrl[spc_pkg::B_PPRI_HI:spc_pkg::B_PPRI_LO]))
        else $error("Fallback priority not the port priority.");

    or_prio_a: assert property (
        in_valid && in_dscp_hit && in_tag_hit && s_ff.ctrl[spc_pkg::B_DSCP]
        && s_ff.ctrl[spc_pkg::B_USRPRI] |=> cls_prio
            == ($past(in_dscp_prio) | $past(in_tag_prio)))
        else $error("Combined priority not ORed.");

    tag_insert_a: assert property (
        eg_in_valid && eg_tagged_rx |=> !eg_insert)
        else $error("Tag inserted on a tagged arrival.");

    tag_strip_a: assert property (
        eg_in_valid && !eg_tagged_rx |=> !eg_strip && eg_vid == $past(eg_src_vid))
        else $error("Untagged arrival modified by stripping.");

    cover_four_q_c: cover property (cls_valid && cls_queue == 2'h3);
    cover_insert_c: cover property (eg_insert);
    cover_strip_c: cover property (eg_strip);
    cover_drop_c: cover property (cls_drop);

endmodule

// ===== spc_pkg.sv
// Purpose: Constants for the port one control register bank.
// Assumes: 8-bit byte address, 16-bit register data.
// Notes:   Field positions are bit indices within the 16-bit word.
package spc_pkg;

    // ==========================================================
    // Register offsets and reset values
    // ==========================================================
    localparam logic [7:0]  OFS_CTRL   = 8'h6c;
    localparam logic [7:0]  OFS_DTAG   = 8'h70;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h7fff;
    localparam logic [15:0] DTAG_RST   = 16'h0001;
    localparam logic [11:0] VID_RST    = 12'h001;

    // ==========================================================
    // Field positions of port_one_control_first, and the VID top bit of the default tag
    // ==========================================================
    localparam int B_LED_HI  = 14;
    localparam int B_LED_LO  = 12;
    localparam int B_SAF_TWO = 11;
    localparam int B_SAF_ONE = 10;
    localparam int B_DROPTAG = 9;
    localparam int B_TWO_Q   = 8;
    localparam int B_STORM   = 7;
    localparam int B_DSCP    = 6;
    localparam int B_USRPRI  = 5;
    localparam int B_PPRI_HI = 4;
    localparam int B_PPRI_LO = 3;
    localparam int B_INSERT  = 2;
    localparam int B_STRIP   = 1;
    localparam int B_FOUR_Q  = 0;
    localparam int B_VID_HI  = 11;

    // ==========================================================
    // Indicator override codes
    // ==========================================================
    localparam logic [2:0] LED_BOTH_OFF = 3'h4;
    localparam logic [2:0] LED_ZERO_ON  = 3'h5;
    localparam logic [2:0] LED_ONE_ON   = 3'h6;
    localparam logic [2:0] LED_BOTH_ON  = 3'h7;

    // ==========================================================
    // Module state
    // ==========================================================
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] dtag;
        logic [15:0] rdata;
        logic        cls_valid;
        logic        cls_drop;
        logic        cls_saf;
        logic        cls_storm;
        logic [1:0]  cls_prio;
        logic [1:0]  cls_queue;
        logic        eg_valid;
        logic        eg_insert;
        logic        eg_strip;
        logic [11:0] eg_vid;
    } spc_state_t;

    typedef struct packed {
        logic ind_zero;
        logic ind_one;
    } spc_led_state_t;

endpackage

// ===== spc_led_ovr.sv
// Purpose: Port indicator override from the three-bit direct field.
// Assumes: Normal indicator levels come from logic on ref_clk.
// Notes:   Outputs are registered, one cycle behind their inputs.
module spc_led_ovr (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Control
    input  wire logic [2:0] led_mode,
    input  wire logic       norm_zero,
    input  wire logic       norm_one,
    // Pins
    output logic            port_indicator_zero,
    output logic            port_indicator_one
);

    spc_pkg::spc_led_state_t s_ff;
    spc_pkg::spc_led_state_t nxt_s;

    // ==========================================================
    // Override decode
    // ==========================================================
    always_comb begin
        nxt_s = s_ff;
        case (led_mode)
            spc_pkg::LED_BOTH_OFF: begin
                nxt_s.ind_zero = 1'b0;
                nxt_s.ind_one  = 1'b0;
            end
            spc_pkg::LED_ZERO_ON: begin
                nxt_s.ind_zero = 1'b1;
                nxt_s.ind_one  = 1'b0;
            end
            spc_pkg::LED_ONE_ON: begin
                nxt_s.ind_zero = 1'b0;
                nxt_s.ind_one  = 1'b1;
            end
            spc_pkg::LED_BOTH_ON: begin
                nxt_s.ind_zero = 1'b1;
                nxt_s.ind_one  = 1'b1;
            end
            default: begin
                nxt_s.ind_zero = norm_zero;
                nxt_s.ind_one  = norm_one;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign port_indicator_zero = s_ff.ind_zero;
    assign port_indicator_one  = s_ff.ind_one;

    // ==========================================================
    // Checks
    // ==========================================================
    led_override_a: assert property (@(posedge ref_clk) disable iff (srst)
        led_mode[2] |=> port_indicator_zero == $past(led_mode[0])
            && port_indicator_one == $past(led_mode[1]))
        else $error("Indicator override does not follow the code.");

    led_normal_a: assert property (@(posedge ref_clk) disable iff (srst)
        !led_mode[2] |=> port_indicator_zero == $past(norm_zero))
        else $error("Indicator not following normal level.");

endmodule

// ===== test_spc_port_ctrl.sv
// Purpose: Self-checking bench for the port one control register bank.
// Assumes: Reads answer in the cycle after the read strobe; decisions one cycle after valid.
// Notes:   Each scenario is a task that drives the ports and judges the outcome itself.
module test_spc_port_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset and ports
    // ==========================================================
    logic        ref_clk = 1'b0;
    logic        srst;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd;
    logic        in_valid, in_tagged, in_sa_hit_one, in_sa_hit_two, in_bcast;
    logic        in_dscp_hit, in_tag_hit;
    logic [1:0]  in_dscp_prio, in_tag_prio, cls_prio, cls_queue;
    logic        cls_valid, cls_drop, cls_saf, cls_storm;
    logic        eg_in_valid, eg_tagged_rx, eg_valid, eg_insert, eg_strip;
    logic [11:0] eg_src_vid, eg_vid, default_vid;
    logic        norm_zero, norm_one, port_indicator_zero, port_indicator_one;
    int          miscompares = 0;
    int          num_checks  = 0;

    always #10 ref_clk = ~ref_clk;

    spc_port_ctrl spc_port_ctrl_inst (
        .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
        .in_tagged(in_tagged), .in_sa_hit_one(in_sa_hit_one), .in_sa_hit_two(in_sa_hit_two),
        .in_bcast(in_bcast), .in_dscp_hit(in_dscp_hit), .in_dscp_prio(in_dscp_prio),
        .in_tag_hit(in_tag_hit), .in_tag_prio(in_tag_prio), .cls_valid(cls_valid),
        .cls_drop(cls_drop), .cls_saf(cls_saf), .cls_storm(cls_storm), .cls_prio(cls_prio),
        .cls_queue(cls_queue), .eg_in_valid(eg_in_valid), .eg_tagged_rx(eg_tagged_rx),
        .eg_src_vid(eg_src_vid), .eg_valid(eg_valid), .eg_insert(eg_insert),
        .eg_strip(eg_strip), .eg_vid(eg_vid), .default_vid(default_vid),
        .norm_zero(norm_zero), .norm_one(norm_one),
        .port_indicator_zero(port_indicator_zero), .port_indicator_one(port_indicator_one)
    );

    // ==========================================================
    // Bus cycles and comparison
    // ==========================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic send_in(input logic tg, input logic h1, input logic h2, input logic bc,
                           input logic dh, input logic [1:0] dp, input logic th,
                           input logic [1:0] tp);
        @(posedge ref_clk);
        in_valid      <= 1'b1;
        in_tagged     <= tg;
        in_sa_hit_one <= h1;
        in_sa_hit_two <= h2;
        in_bcast      <= bc;
        in_dscp_hit   <= dh;
        in_dscp_prio  <= dp;
        in_tag_hit    <= th;
        in_tag_prio   <= tp;
        @(posedge ref_clk);
        in_valid      <= 1'b0;
        #1;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs();
        logic [15:0] d;
        chk(16'(default_vid), 16'h0001, "default vid at reset");
        rd(spc_pkg::OFS_CTRL, d);
        chk(d, spc_pkg::CTRL_RST, "control at reset");
        rd(spc_pkg::OFS_DTAG, d);
        chk(d, spc_pkg::DTAG_RST, "default tag at reset");
        @(posedge ref_clk);
        #1;
        chk(reg_rdata, 16'h0000, "read data held too long");
        wr(spc_pkg::OFS_CTRL, 16'hffff);
        rd(spc_pkg::OFS_CTRL, d);
        chk(d, 16'h7fff, "top bit not read only");
        wr(8'h6e, 16'h1234);
        rd(8'h6e, d);
        chk(d, 16'h0000, "unmapped read");
        rd(spc_pkg::OFS_CTRL, d);
        chk(d, 16'h7fff, "unmapped write disturbed control");
        wr(spc_pkg::OFS_DTAG, 16'hf5a7);
        rd(spc_pkg::OFS_DTAG, d);
        chk(d, 16'hf5a7, "default tag readback");
        chk(16'(default_vid), 16'h05a7, "default vid output");
        wr(spc_pkg::OFS_DTAG, spc_pkg::DTAG_RST);
    endtask

    task automatic t_led();
        logic ez, eo;
        for (int n = 0; n < 2; n++) begin
            for (int c = 0; c < 8; c++) begin
                @(posedge ref_clk);
                norm_zero <= ~n[0];
                norm_one  <= n[0];
                wr(spc_pkg::OFS_CTRL, 16'(c) << 12);
                repeat (2) @(posedge ref_clk);
                #1;
                ez = c[2] ? c[0] : ~n[0];
                eo = c[2] ? c[1] : n[0];
                chk(16'(port_indicator_zero), 16'(ez), "indicator zero");
                chk(16'(port_indicator_one), 16'(eo), "indicator one");
            end
        end
    endtask

    task automatic t_flags();
        logic [15:0] c;
        logic        tg;
        for (int j = 0; j < 16; j++) begin
            c = {4'h0, j[2], j[1], j[0], 1'b0, j[3], 7'h00};
            wr(spc_pkg::OFS_CTRL, c);
            for (int k = 0; k < 2; k++) begin
                tg = k[0];
                send_in(tg, ~tg, tg, 1'b1, 1'b0, 2'b00, 1'b0, 2'b00);
                chk(16'(cls_valid), 16'h0001, "decision valid");
                chk(16'(cls_drop), 16'(c[9] & tg), "tagged drop");
                chk(16'(cls_saf), 16'((c[10] & ~tg) | (c[11] & tg)), "filter");
                chk(16'(cls_storm), 16'(c[7]), "storm protection");
            end
        end
        @(posedge ref_clk);
        #1;
        chk(16'(cls_valid), 16'h0000, "decision valid held too long");
    endtask

    task automatic t_prio();
        logic [15:0] c;
        logic [1:0]  pp, ep, eq;
        logic        de, te, dh, th;
        for (int q = 0; q < 3; q++) begin
            for (int i = 0; i < 16; i++) begin
                pp = 2'(i + q);
                {th, dh, te, de} = 4'(i);
                c = {7'h00, q == 1, 1'b0, de, te, pp, 2'b00, q == 2};
                wr(spc_pkg::OFS_CTRL, c);
                send_in(1'b0, 1'b0, 1'b0, 1'b0, dh, 2'b01, th, 2'b10);
                ep = ({2{de & dh}} & 2'b01) | ({2{te & th}} & 2'b10);
                ep = ((de & dh) | (te & th)) ? ep : pp;
                eq = (q == 2) ? ep : (q == 1) ? {1'b0, ep[1]} : 2'b00;
                chk(16'(cls_prio), 16'(ep), "priority");
                chk(16'(cls_queue), 16'(eq), "queue");
            end
        end
    endtask

    task automatic t_egress();
        logic [15:0] c;
        logic [11:0] vid;
        logic        tg;
        for (int j = 0; j < 4; j++) begin
            c = {13'h0000, j[1], j[0], 1'b0};
            wr(spc_pkg::OFS_CTRL, c);
            for (int k = 0; k < 2; k++) begin
                tg = k[0];
                vid = tg ? 12'h123 : 12'h9bc;
                @(posedge ref_clk);
                eg_in_valid  <= 1'b1;
                eg_tagged_rx <= tg;
                eg_src_vid   <= vid;
                @(posedge ref_clk);
                eg_in_valid  <= 1'b0;
                #1;
                chk(16'(eg_valid), 16'h0001, "egress valid");
                chk(16'(eg_insert), 16'(c[2] & ~tg), "tag insert");
                chk(16'(eg_strip), 16'(c[1] & tg), "tag strip");
                if (c[2] & ~tg) chk(16'(eg_vid), 16'(vid), "inserted vid");
            end
        end
    endtask

    task automatic t_timing();
        wr(spc_pkg::OFS_CTRL, 16'h0000);
        @(posedge ref_clk);
        reg_addr  <= spc_pkg::OFS_CTRL;
        reg_wdata <= 16'h0200;
        reg_wr    <= 1'b1;
        in_valid  <= 1'b1;
        in_tagged <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
        chk(16'(cls_drop), 16'h0000, "same cycle write leaked");
        @(posedge ref_clk);
        in_valid  <= 1'b0;
        #1;
        chk(16'(cls_drop), 16'h0001, "new value not applied");
        @(posedge ref_clk);
        reg_addr  <= spc_pkg::OFS_CTRL;
        reg_wdata <= 16'h8123;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge ref_clk);
        reg_rd    <= 1'b0;
        #1;
        chk(reg_rdata, 16'h0123, "back to back write then read");
    endtask

    // ==========================================================
    // Verdict and main sequence
    // ==========================================================
    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge ref_clk);
        miscompares++;
        $display("[FAIL] %0t run did not finish in time", $time);
        summarize();
    end

    initial begin
        srst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {in_valid, in_tagged, in_sa_hit_one, in_sa_hit_two, in_bcast} = '0;
        {in_dscp_hit, in_dscp_prio, in_tag_hit, in_tag_prio} = '0;
        {eg_in_valid, eg_tagged_rx, eg_src_vid, norm_zero, norm_one} = '0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_led();
        t_flags();
        t_prio();
        t_egress();
        t_timing();
        summarize();
    end
endmodule
